// file: rtl/slpmc_map.vh
`ifndef SLPMC_MAP_VH
`define SLPMC_MAP_VH
// Clock period in picoseconds
`define SLPMC_CLK_PS         4000
// Glitch filter: low or high must stand this long, in ns
`define SLPMC_FILT_NS        100
`define SLPMC_FILT_CYC       ((`SLPMC_FILT_NS*1000+`SLPMC_CLK_PS-1)/`SLPMC_CLK_PS)
// Entry delay after a filtered low, in ns
`define SLPMC_ENTRY_NS       300
`define SLPMC_ENTRY_CYC      ((`SLPMC_ENTRY_NS*1000+`SLPMC_CLK_PS-1)/`SLPMC_CLK_PS)
// Wake-up delay after a filtered high, in ns
`define SLPMC_WAKE_NS        1000
`define SLPMC_WAKE_CYC       ((`SLPMC_WAKE_NS*1000+`SLPMC_CLK_PS-1)/`SLPMC_CLK_PS)
// Power state codes
`define SLPMC_ST_NORMAL      2'h0
`define SLPMC_ST_ENTER       2'h1
`define SLPMC_ST_SLEEP       2'h2
`define SLPMC_ST_WAKE        2'h3
`endif

// file: rtl/slpmc_filter.v
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser followed by a stable-time filter
module slpmc_filter #(
  parameter integer FILT_CYC = 25,
  parameter integer CW       = 8
) (
  input  wire i_sys_clk,
  input  wire i_rst,
  input  wire i_pin_n,
  output reg  o_level
);
  reg          s1_r;
  reg          s2_r;
  reg          s3_r;
  reg [CW-1:0] cnt_r;

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      s1_r    <= 1'b1;
      s2_r    <= 1'b1;
      s3_r    <= 1'b1;
      cnt_r   <= {CW{1'b0}};
      o_level <= 1'b1;
    end else begin
      s1_r <= i_pin_n;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // Short pulses restart the count and never reach the output
      if (s2_r != s3_r || s3_r == o_level) begin
        cnt_r <= {CW{1'b0}};
      end else if (cnt_r == FILT_CYC[CW-1:0] - 1'b1) begin
        cnt_r   <= {CW{1'b0}};
        o_level <= s3_r;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/slpmc_ctrl.v
// What this block does
// - Request pin alone selects sleep or normal
// - Sleep stops user logic, tristates I/O
// - Sleep entry discards registers and block RAM
// - Test and programming logic off in sleep
// - Pull-up default, synchronised, glitch filtered request
// - Enter sleep shortly after valid low
// - Resume normal operation after wake delay
`include "slpmc_map.vh"
`timescale 1ns/1ps
`default_nettype none
module slpmc_ctrl #(
  parameter integer NUM_IO    = 8,
  parameter integer FILT_CYC  = `SLPMC_FILT_CYC,
  parameter integer ENTRY_CYC = `SLPMC_ENTRY_CYC,
  parameter integer WAKE_CYC  = `SLPMC_WAKE_CYC
) (
  input  wire              i_sys_clk,
  input  wire              i_rst,
  input  wire              i_low_power_req_n,
  input  wire [NUM_IO-1:0] i_user_oe,
  output reg  [NUM_IO-1:0] o_io_oe,
  output reg               o_user_run,
  output reg               o_user_rst,
  output reg               o_ram_clear,
  output reg               o_test_enable,
  output reg               o_asleep,
  output reg  [1:0]        o_state
);
  localparam [1:0] ST_NORMAL = `SLPMC_ST_NORMAL;
  localparam [1:0] ST_ENTER  = `SLPMC_ST_ENTER;
  localparam [1:0] ST_SLEEP  = `SLPMC_ST_SLEEP;
  localparam [1:0] ST_WAKE   = `SLPMC_ST_WAKE;
  localparam integer CW = 10;

  wire          req_hi;
  reg  [1:0]    state_r;
  reg  [1:0]    state_nxt;
  reg  [CW-1:0] cnt_r;
  reg  [CW-1:0] cnt_nxt;
  wire          run_nxt;

  // A floating pin is pulled high outside; reset state is also high
  slpmc_filter #(
    .FILT_CYC (FILT_CYC),
    .CW       (CW)
  ) u_filter (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_pin_n   (i_low_power_req_n),
    .o_level   (req_hi)
  );

  // Only the filtered pin level moves the state machine
  always @* begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      ST_NORMAL: begin
        cnt_nxt = {CW{1'b0}};
        if (!req_hi) begin
          state_nxt = ST_ENTER;
        end
      end
      ST_ENTER: begin
        if (req_hi) begin
          state_nxt = ST_NORMAL;
          cnt_nxt   = {CW{1'b0}};
        end else if (cnt_r == ENTRY_CYC[CW-1:0] - 1'b1) begin
          state_nxt = ST_SLEEP;
          cnt_nxt   = {CW{1'b0}};
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      ST_SLEEP: begin
        cnt_nxt = {CW{1'b0}};
        if (req_hi) begin
          state_nxt = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (!req_hi) begin
          state_nxt = ST_SLEEP;
          cnt_nxt   = {CW{1'b0}};
        end else if (cnt_r == WAKE_CYC[CW-1:0] - 1'b1) begin
          state_nxt = ST_NORMAL;
          cnt_nxt   = {CW{1'b0}};
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      default: begin
        state_nxt = ST_NORMAL;
        cnt_nxt   = {CW{1'b0}};
      end
    endcase
  end

  assign run_nxt = (state_nxt == ST_NORMAL);

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_r       <= ST_NORMAL;
      cnt_r         <= {CW{1'b0}};
      o_io_oe       <= {NUM_IO{1'b0}};
      o_user_run    <= 1'b0;
      o_user_rst    <= 1'b1;
      o_ram_clear   <= 1'b0;
      o_test_enable <= 1'b0;
      o_asleep      <= 1'b0;
      o_state       <= ST_NORMAL;
    end else begin
      state_r       <= state_nxt;
      cnt_r         <= cnt_nxt;
      o_state       <= state_nxt;
      o_user_run    <= run_nxt;
      o_io_oe       <= run_nxt ? i_user_oe : {NUM_IO{1'b0}};
      // User reset held outside normal so wake starts clean
      o_user_rst    <= !run_nxt;
      o_ram_clear   <= (state_r == ST_ENTER) &&
                       (state_nxt == ST_SLEEP);
      o_test_enable <= (state_nxt != ST_SLEEP);
      o_asleep      <= (state_nxt == ST_SLEEP);
    end
  end
endmodule
`default_nettype wire

// file: sim/slpmc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module slpmc_chk #(
  parameter integer NUM_IO = 8, FILT_CYC = 2, ENTRY_CYC = 20, WAKE_CYC = 4
) (
  input wire logic              i_sys_clk, i_rst, i_low_power_req_n,
  input wire logic [NUM_IO-1:0] i_user_oe, o_io_oe,
  input wire logic              o_user_run, o_ram_clear, o_test_enable,
  input wire logic              o_user_rst,
  input wire logic              o_asleep,
  input wire logic [1:0]        o_state
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Masks the first edge after reset, when outputs still hold reset values
  logic live_r = 1'b0;
  always @(posedge i_sys_clk) live_r <= !i_rst;
  sequence s_slept; o_state == 2'h2 && $past(o_state) == 2'h1; endsequence
  property p_run; live_r |-> o_user_run == (o_state == 2'h0); endproperty
  property p_slp; live_r |-> o_asleep == (o_state == 2'h2); endproperty
  property p_tst; live_r |-> o_test_enable == (o_state != 2'h2); endproperty
  property p_urst; live_r |-> o_user_rst == (o_state != 2'h0); endproperty
  property p_oe;
    live_r |-> o_io_oe == (o_state == 2'h0 ? $past(i_user_oe) : '0);
  endproperty
  property p_ram;
    live_r |-> o_ram_clear == (o_state == 2'h2 && $past(o_state) == 2'h1);
  endproperty
  property p_ent; s_slept |-> $past(o_state, ENTRY_CYC) == 2'h1; endproperty
  property p_wak;
    o_state == 2'h0 && $past(o_state) == 2'h3
      |-> $past(o_state, WAKE_CYC) == 2'h3;
  endproperty
  property p_flt;
    o_state == 2'h1 && $past(o_state) == 2'h0
      |-> !$past(i_low_power_req_n, FILT_CYC);
  endproperty
  a_run: assert property (p_run) else $error("run level wrong");
  a_slp: assert property (p_slp) else $error("asleep wrong");
  a_tst: assert property (p_tst) else $error("test enable wrong");
  a_urst: assert property (p_urst) else $error("user reset wrong");
  a_oe: assert property (p_oe) else $error("io enables wrong");
  a_ram: assert property (p_ram) else $error("ram clear wrong");
  a_ent: assert property (p_ent) else $error("entry too early");
  a_wak: assert property (p_wak) else $error("wake too early");
  a_flt: assert property (p_flt) else $error("unfiltered entry");
endmodule
`default_nettype wire

// file: sim/slpmc_host.sv
`timescale 1ns/1ps
`default_nettype none
module slpmc_host (
  input  wire logic i_sys_clk,
  input  wire logic i_req,
  output var logic  o_pin_n = 1'b1
);
  // Requests come only in normal running, never while configuring
  // The pin follows the request at once, so a bench change on the
  // falling edge is never raced against the model's own sampling
  always @(i_req) o_pin_n = !i_req;
endmodule
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 0, rst = 1, req = 0, seen;
  logic [7:0] uoe = 8'h00;
  wire pin_n, run, urst, rclr, ten, slp;
  wire [7:0] oe;
  wire [1:0] st;
  int miscompares = 0, n_compared = 0, i;
  initial forever #2 clk = ~clk;
  slpmc_host HOST (.i_sys_clk(clk), .i_req(req), .o_pin_n(pin_n));
  slpmc_ctrl #(.FILT_CYC(2), .ENTRY_CYC(20), .WAKE_CYC(4)) DUT (
    .i_sys_clk(clk), .i_rst(rst), .i_low_power_req_n(pin_n),
    .i_user_oe(uoe), .o_io_oe(oe), .o_user_run(run), .o_user_rst(urst),
    .o_ram_clear(rclr), .o_test_enable(ten), .o_asleep(slp), .o_state(st));
  function automatic logic [7:0] exp_oe(input logic [1:0] s, logic [7:0] u);
    return s == 2'h0 ? u : 8'h00;
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic run_to(input logic [1:0] s);
    for (i = 0; i < 400 && st !== s; i++) begin
      @(negedge clk);
      seen |= rclr;
      chk("io_oe", exp_oe(st, uoe), oe);
      uoe = $urandom;
    end
  endtask
  initial begin
    void'($urandom(32'h9a9f0682));
    repeat (8) @(negedge clk);
    rst = 0;
    req = 1;
    @(negedge clk);
    req = 0;
    repeat (20) @(negedge clk);
    chk("state", 8'h0, st);
    for (int t = 0; t < 3; t++) begin
      seen = 0;
      req = 1;
      run_to(t ? 2'h2 : 2'h1);
      chk("test_en", t ? 8'h0 : 8'h1, ten);
      chk("asleep", t ? 8'h1 : 8'h0, slp);
      chk("user_rst_held", 8'h1, urst);
      req = 0;
      run_to(2'h0);
      chk("ram_clear", t ? 8'h1 : 8'h0, seen);
      chk("user_rst", 8'h0, urst);
      chk("run", 8'h1, run);
      $display("test %0d done", t);
    end
    wrap_up;
  end
  initial begin
    #40000;
    miscompares++;
    wrap_up;
  end
endmodule
bind slpmc_ctrl slpmc_chk #(.NUM_IO(NUM_IO), .FILT_CYC(FILT_CYC),
  .ENTRY_CYC(ENTRY_CYC), .WAKE_CYC(WAKE_CYC)) CHK (.*);
`default_nettype wire
